// [pkg/dacg_pkg.sv]
// register map, field layout, reset values and lookup helper of the clock generator register slice
package dacg_pkg;
  localparam logic [7:0]  DACG_ADDR_REVISION   = 8'h00;
  localparam logic [7:0]  DACG_ADDR_DIV_HIGH   = 8'h01;
  localparam logic [7:0]  DACG_ADDR_DIV_LOW    = 8'h02;
  localparam logic [7:0]  DACG_ADDR_CLKGEN     = 8'h03;
  localparam logic [7:0]  DACG_ADDR_PHASE      = 8'h04;
  localparam logic [7:0]  DACG_ADDR_LINES_HIGH = 8'h26;
  localparam logic [7:0]  DACG_ADDR_LINES_LOW  = 8'h27;
  localparam logic [7:0]  DACG_ADDR_TEST_A     = 8'h28;
  localparam logic [7:0]  DACG_ADDR_TEST_B     = 8'h29;
  localparam logic [7:0]  DACG_ADDR_RSVD_A     = 8'h2A;
  localparam logic [7:0]  DACG_ADDR_RSVD_B     = 8'h2B;
  localparam logic [7:0]  DACG_ADDR_OFS_HOLD   = 8'h2C;
  localparam logic [7:0]  DACG_ADDR_TEST_C     = 8'h2D;
  localparam logic [7:0]  DACG_ADDR_TEST_D     = 8'h2E;
  localparam logic [7:0]  DACG_ADDR_GAIN_CTRL  = 8'h3C;
  // field positions
  localparam int          DACG_BAND_LSB        = 6;
  localparam int          DACG_PUMP_LSB        = 3;
  localparam int          DACG_EXT_CLK_BIT     = 2;
  localparam int          DACG_PHASE_LSB       = 3;
  localparam int          DACG_DIV_LOW_LSB     = 4;
  localparam int          DACG_OFS_HOLD_BIT    = 4;
  localparam int          DACG_GAIN_HOLD_BIT   = 3;
  // reset values
  localparam logic [7:0]  DACG_RST_DIV_HIGH    = 8'h69;
  localparam logic [7:0]  DACG_RST_DIV_LOW     = 8'hD0;
  localparam logic [11:0] DACG_RST_DIVISOR     = 12'h69D;
  localparam logic [7:0]  DACG_RST_CLKGEN      = 8'h48;
  localparam logic [7:0]  DACG_RST_PHASE       = 8'h80;
  localparam logic [7:0]  DACG_RST_TEST_A      = 8'hBF;
  localparam logic [7:0]  DACG_RST_TEST_B      = 8'h02;
  localparam logic [7:0]  DACG_RST_OFS_HOLD    = 8'h00;
  localparam logic [7:0]  DACG_RST_TEST_CD     = 8'hF0;
  localparam logic [7:0]  DACG_RST_GAIN_CTRL   = 8'h00;
  localparam logic [7:0]  DACG_ZERO_BYTE       = 8'h00;
  // values software must load into the test registers
  localparam logic [7:0]  DACG_REQ_TEST_A      = 8'hBF;
  localparam logic [7:0]  DACG_REQ_TEST_B      = 8'h02;
  localparam logic [7:0]  DACG_REQ_TEST_C      = 8'hE8;
  localparam logic [7:0]  DACG_REQ_TEST_D      = 8'hE0;
  localparam logic [11:0] DACG_DIV_MIN         = 12'h002;
  localparam logic [2:0]  DACG_GAIN_ON         = 3'h6;
  localparam logic [15:0] DACG_PHASE_STEP_CDEG = 16'h0465;
  localparam logic [7:0]  DACG_REVISION_DFLT   = 8'h5A; // arbitrary value

  // loop filter drive current in microamps per code
  function automatic logic [10:0] dacg_pump_ua(input logic [2:0] code);
    logic [10:0] ua;
    ua = 11'h032;
    case (code)
      3'h0:    ua = 11'h032;
      3'h1:    ua = 11'h064;
      3'h2:    ua = 11'h096;
      3'h3:    ua = 11'h0FA;
      3'h4:    ua = 11'h15E;
      3'h5:    ua = 11'h1F4;
      3'h6:    ua = 11'h2EE;
      default: ua = 11'h5DC;
    endcase
    return ua;
  endfunction : dacg_pump_ua
endpackage : dacg_pkg

// [pkg/dacg_wide_if.sv]
// carrier between the register decoder and the wide-setting latch
`timescale 1ns/1ps
interface dacg_wide_if;
  logic        wr_high;
  logic        wr_low;
  logic [7:0]  wdata;
  logic [7:0]  high_q;
  logic [7:0]  low_q;
  logic [11:0] value;
  logic        commit;
  modport ctrl  (output wr_high, output wr_low, output wdata,
                 input high_q, input low_q, input value, input commit);
  modport latch (input wr_high, input wr_low, input wdata,
                 output high_q, output low_q, output value, output commit);
endinterface : dacg_wide_if

// [logic/dacg_wide_latch.sv]
// 12-bit setting split over two registers, taken into use on the low-part write
`timescale 1ns/1ps
module dacg_wide_latch (
  input  wire logic i_clk_sys,
  input  wire logic i_rstn,
  dacg_wide_if.latch bus
);
  import dacg_pkg::*;

  logic [7:0]  high_r;
  logic [7:0]  low_r;
  logic [11:0] value_r;
  logic        commit_r;
  logic [11:0] cand;

  // candidate uses the new low nibble with the stored high part
  assign cand = {high_r, bus.wdata[7:DACG_DIV_LOW_LSB]};

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      high_r <= DACG_RST_DIV_HIGH;
    end else if (bus.wr_high) begin
      high_r <= bus.wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      low_r    <= DACG_RST_DIV_LOW;
      value_r  <= DACG_RST_DIVISOR;
      commit_r <= 1'b0;
    end else begin
      commit_r <= 1'b0;
      if (bus.wr_low) begin
        low_r <= {bus.wdata[7:DACG_DIV_LOW_LSB], 4'h0};
        // ratios below the floor are refused, the running one stays
        if (cand >= DACG_DIV_MIN) begin
          value_r  <= cand;
          commit_r <= 1'b1;
        end
      end
    end
  end

  assign bus.high_q = high_r;
  assign bus.low_q  = low_r;
  assign bus.value  = value_r;
  assign bus.commit = commit_r;

  a_high_alone_holds : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    bus.wr_high && !bus.wr_low |=> $stable(value_r))
    else $error("divisor changed on a high-part write");
  a_low_commits_value : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    bus.wr_low && cand >= DACG_DIV_MIN |=> value_r == $past(cand) && commit_r)
    else $error("low-part write did not load the divisor");
  a_divisor_range_ok : assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    value_r >= DACG_DIV_MIN)
    else $error("divisor below two");
endmodule : dacg_wide_latch

// [logic/dacg_config_regs.sv]
// configuration and status register slice of the digitizer clock generator
`timescale 1ns/1ps
module dacg_config_regs #(
  parameter logic [7:0] SILICON_REVISION = dacg_pkg::DACG_REVISION_DFLT // arbitrary value
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rd_data,
  output logic             o_rd_valid,
  output logic             o_regs_ready,
  input  wire logic [11:0] i_lines_per_frame,
  output logic      [11:0] o_line_clock_divisor,
  output logic             o_divisor_update,
  output logic             o_divisor_in_use,
  output logic      [1:0]  o_oscillator_band_select,
  output logic      [3:0]  o_post_divider_ratio,
  output logic      [2:0]  o_pump_current_code,
  output logic      [10:0] o_pump_current_ua,
  output logic             o_external_pixel_clock_select,
  output logic      [4:0]  o_sampling_phase,
  output logic      [15:0] o_phase_shift_cdeg,
  output logic             o_offset_continuous,
  output logic             o_offset_update_pulse,
  output logic             o_gain_match_enable,
  output logic             o_gain_update_allow,
  output logic             o_test_regs_ok
);
  import dacg_pkg::*;

  default clocking dc @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  dacg_wide_if div_bus ();

  logic       ready_r;
  logic       ofs_seen_r;
  logic [7:0] clkgen_r;
  logic [7:0] phase_r;
  logic [7:0] test_a_r;
  logic [7:0] test_b_r;
  logic [7:0] test_c_r;
  logic [7:0] test_d_r;
  logic [7:0] ofs_hold_r;
  logic [7:0] gain_ctrl_r;
  logic [7:0] rd_data_r;
  logic       rd_valid_r;
  logic [7:0] rd_data_nxt;
  logic       wr_ok;
  logic [2:0] gain_mode;

  // accesses are taken only once every default is in place
  assign wr_ok = i_wr_en && ready_r;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= 1'b1;
    end
  end

  assign div_bus.wr_high = wr_ok && i_addr == DACG_ADDR_DIV_HIGH;
  assign div_bus.wr_low  = wr_ok && i_addr == DACG_ADDR_DIV_LOW;
  assign div_bus.wdata   = i_wdata;

  dacg_wide_latch u_divisor (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .bus       (div_bus)
  );

  // clock generator controls
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      clkgen_r <= DACG_RST_CLKGEN;
    end else if (wr_ok && i_addr == DACG_ADDR_CLKGEN) begin
      clkgen_r <= {i_wdata[7:DACG_EXT_CLK_BIT], 2'h0};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      phase_r <= DACG_RST_PHASE;
    end else if (wr_ok && i_addr == DACG_ADDR_PHASE) begin
      phase_r <= {i_wdata[7:DACG_PHASE_LSB], 3'h0};
    end
  end

  // test registers; the first two reset to their working values, only the host gives the last two theirs
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      test_a_r <= DACG_RST_TEST_A;
      test_b_r <= DACG_RST_TEST_B;
      test_c_r <= DACG_RST_TEST_CD;
      test_d_r <= DACG_RST_TEST_CD;
    end else if (wr_ok) begin
      if (i_addr == DACG_ADDR_TEST_A) begin
        test_a_r <= i_wdata;
      end
      if (i_addr == DACG_ADDR_TEST_B) begin
        test_b_r <= i_wdata;
      end
      if (i_addr == DACG_ADDR_TEST_C) begin
        test_c_r <= i_wdata;
      end
      if (i_addr == DACG_ADDR_TEST_D) begin
        test_d_r <= i_wdata;
      end
    end
  end

  // offset and gain matching control; other bits stored as written
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      ofs_hold_r  <= DACG_RST_OFS_HOLD;
      gain_ctrl_r <= DACG_RST_GAIN_CTRL;
    end else if (wr_ok) begin
      if (i_addr == DACG_ADDR_OFS_HOLD) begin
        ofs_hold_r <= i_wdata;
      end
      if (i_addr == DACG_ADDR_GAIN_CTRL) begin
        gain_ctrl_r <= i_wdata;
      end
    end
  end

  // one-time offset update: fires once after reset and once per hold-mode write that leaves the continuous bit clear
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      ofs_seen_r            <= 1'b0;
      o_offset_update_pulse <= 1'b0;
    end else begin
      o_offset_update_pulse <= 1'b0;
      if (!ofs_hold_r[DACG_OFS_HOLD_BIT] && !ofs_seen_r) begin
        o_offset_update_pulse <= 1'b1;
        ofs_seen_r            <= 1'b1;
      end
      if (wr_ok && i_addr == DACG_ADDR_OFS_HOLD) begin
        ofs_seen_r <= 1'b0;
      end
    end
  end

  assign gain_mode = gain_ctrl_r[2:0];

  // derived controls, registered so the analog side sees clean levels
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_oscillator_band_select      <= DACG_RST_CLKGEN[7:DACG_BAND_LSB];
      o_post_divider_ratio          <= 4'h4;
      o_pump_current_code           <= DACG_RST_CLKGEN[5:DACG_PUMP_LSB];
      o_pump_current_ua             <= dacg_pump_ua(DACG_RST_CLKGEN[5:DACG_PUMP_LSB]);
      o_external_pixel_clock_select <= 1'b0;
      o_divisor_in_use              <= 1'b1;
      o_sampling_phase              <= DACG_RST_PHASE[7:DACG_PHASE_LSB];
      o_phase_shift_cdeg            <= 16'(DACG_RST_PHASE[7:DACG_PHASE_LSB] * DACG_PHASE_STEP_CDEG);
      o_offset_continuous           <= 1'b0;
      o_gain_match_enable           <= 1'b0;
      o_gain_update_allow           <= 1'b0;
      o_test_regs_ok                <= 1'b0;
    end else begin
      o_oscillator_band_select <= clkgen_r[7:DACG_BAND_LSB];
      // post-divider follows the band: lower bands run the oscillator faster
      case (clkgen_r[7:DACG_BAND_LSB])
        2'h0:    o_post_divider_ratio <= 4'h8;
        2'h1:    o_post_divider_ratio <= 4'h4;
        2'h2:    o_post_divider_ratio <= 4'h2;
        default: o_post_divider_ratio <= 4'h1;
      endcase
      o_pump_current_code           <= clkgen_r[5:DACG_PUMP_LSB];
      o_pump_current_ua             <= dacg_pump_ua(clkgen_r[5:DACG_PUMP_LSB]);
      o_external_pixel_clock_select <= clkgen_r[DACG_EXT_CLK_BIT];
      o_divisor_in_use              <= !clkgen_r[DACG_EXT_CLK_BIT];
      o_sampling_phase              <= phase_r[7:DACG_PHASE_LSB];
      o_phase_shift_cdeg            <= 16'(phase_r[7:DACG_PHASE_LSB] * DACG_PHASE_STEP_CDEG);
      o_offset_continuous           <= ofs_hold_r[DACG_OFS_HOLD_BIT];
      o_gain_match_enable           <= gain_mode == DACG_GAIN_ON;
      o_gain_update_allow           <= gain_mode == DACG_GAIN_ON && gain_ctrl_r[DACG_GAIN_HOLD_BIT];
      o_test_regs_ok                <= test_a_r == DACG_REQ_TEST_A && test_b_r == DACG_REQ_TEST_B
                                       && test_c_r == DACG_REQ_TEST_C && test_d_r == DACG_REQ_TEST_D;
    end
  end

  // divisor drives the line clock; external clock mode ignores it downstream
  assign o_line_clock_divisor = div_bus.value;
  assign o_divisor_update     = div_bus.commit;

  // read mux; unmapped and reserved locations read zero
  always_comb begin
    rd_data_nxt = DACG_ZERO_BYTE;
    case (i_addr)
      DACG_ADDR_REVISION:   rd_data_nxt = SILICON_REVISION;
      DACG_ADDR_DIV_HIGH:   rd_data_nxt = div_bus.high_q;
      DACG_ADDR_DIV_LOW:    rd_data_nxt = div_bus.low_q;
      DACG_ADDR_CLKGEN:     rd_data_nxt = clkgen_r;
      DACG_ADDR_PHASE:      rd_data_nxt = phase_r;
      DACG_ADDR_LINES_HIGH: rd_data_nxt = i_lines_per_frame[11:4];
      DACG_ADDR_LINES_LOW:  rd_data_nxt = {i_lines_per_frame[3:0], 4'h0};
      DACG_ADDR_TEST_A:     rd_data_nxt = test_a_r;
      DACG_ADDR_TEST_B:     rd_data_nxt = test_b_r;
      DACG_ADDR_RSVD_A:     rd_data_nxt = DACG_ZERO_BYTE;
      DACG_ADDR_RSVD_B:     rd_data_nxt = DACG_ZERO_BYTE;
      DACG_ADDR_OFS_HOLD:   rd_data_nxt = ofs_hold_r;
      DACG_ADDR_TEST_C:     rd_data_nxt = test_c_r;
      DACG_ADDR_TEST_D:     rd_data_nxt = test_d_r;
      DACG_ADDR_GAIN_CTRL:  rd_data_nxt = gain_ctrl_r;
      default:              rd_data_nxt = DACG_ZERO_BYTE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      rd_data_r  <= DACG_ZERO_BYTE;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= i_rd_en && ready_r;
      if (i_rd_en && ready_r) begin
        rd_data_r <= rd_data_nxt;
      end
    end
  end

  assign o_rd_data    = rd_data_r;
  assign o_rd_valid   = rd_valid_r;
  assign o_regs_ready = ready_r;

  a_lines_low_read : assert property (
    i_rd_en && ready_r && i_addr == DACG_ADDR_LINES_LOW
    |=> o_rd_valid && o_rd_data == {$past(i_lines_per_frame[3:0]), 4'h0})
    else $error("lines-per-frame low nibble misread");
  a_lines_high_read : assert property (
    i_rd_en && ready_r && i_addr == DACG_ADDR_LINES_HIGH
    |=> o_rd_data == $past(i_lines_per_frame[11:4]))
    else $error("lines-per-frame high byte misread");
  a_reserved_reads_zero : assert property (
    i_rd_en && ready_r && (i_addr == DACG_ADDR_RSVD_A || i_addr == DACG_ADDR_RSVD_B)
    |=> o_rd_data == DACG_ZERO_BYTE)
    else $error("reserved location read nonzero");
  a_revision_read : assert property (
    i_rd_en && ready_r && i_addr == DACG_ADDR_REVISION |=> o_rd_data == SILICON_REVISION)
    else $error("revision read wrong");
  a_offset_mode_follows : assert property (
    wr_ok && i_addr == DACG_ADDR_OFS_HOLD |=> ##1 o_offset_continuous == $past(i_wdata[DACG_OFS_HOLD_BIT], 2))
    else $error("offset mode not applied");
  a_oneshot_single : assert property (
    o_offset_update_pulse && !(wr_ok && i_addr == DACG_ADDR_OFS_HOLD) ##1 !(wr_ok && i_addr == DACG_ADDR_OFS_HOLD)
    |=> !o_offset_update_pulse)
    else $error("one-time offset update repeated");
  a_gain_enable_code : assert property (
    o_gain_match_enable |-> $past(gain_mode) == DACG_GAIN_ON)
    else $error("gain matching enabled by wrong code");
  a_gain_hold_freezes : assert property (
    o_gain_update_allow |-> $past(gain_ctrl_r[DACG_GAIN_HOLD_BIT]) && o_gain_match_enable)
    else $error("gain updates allowed while held");
  a_band_post_divider : assert property (
    wr_ok && i_addr == DACG_ADDR_CLKGEN && i_wdata[7:DACG_BAND_LSB] == 2'h3
    |=> ##1 o_oscillator_band_select == 2'h3 && o_post_divider_ratio == 4'h1)
    else $error("band or post-divider not applied");
  a_ext_clock_select : assert property (
    wr_ok && i_addr == DACG_ADDR_CLKGEN |=> ##1 o_external_pixel_clock_select == $past(i_wdata[DACG_EXT_CLK_BIT], 2)
    && o_divisor_in_use != o_external_pixel_clock_select)
    else $error("pixel clock source not applied");
  a_phase_shift_scaled : assert property (
    o_phase_shift_cdeg == 16'(o_sampling_phase * DACG_PHASE_STEP_CDEG))
    else $error("phase shift not in 11.25 degree steps");
  a_reset_defaults : assert property (@(posedge i_clk_sys)
    $rose(i_rstn) |-> o_line_clock_divisor == DACG_RST_DIVISOR && !o_regs_ready && o_sampling_phase == 5'h10)
    else $error("defaults not loaded at reset");

  // register storage and the one-edge lag of the derived outputs
  a_ready_after_reset : assert property (@(posedge i_clk_sys)
    $rose(i_rstn) |=> o_regs_ready && !o_rd_valid)
    else $error("port not ready one edge after reset release");
  a_read_valid_pulse : assert property (
    o_rd_valid |-> $past(i_rd_en) && $past(ready_r))
    else $error("read answer without an accepted read");
  a_update_follows_low : assert property (
    o_divisor_update |-> $past(div_bus.wr_low))
    else $error("divisor update without a low-part write");
  a_post_divider_band : assert property (
    o_post_divider_ratio == 4'(4'h8 >> $past(clkgen_r[7:DACG_BAND_LSB])))
    else $error("post-divider does not follow the band");
  a_pump_code_follows : assert property (
    wr_ok && i_addr == DACG_ADDR_CLKGEN |=> ##1 o_pump_current_code == $past(i_wdata[5:DACG_PUMP_LSB], 2))
    else $error("pump current code not applied");
  a_pump_current_top : assert property (
    o_pump_current_code == 3'h7 |-> o_pump_current_ua == 11'h5DC)
    else $error("top pump current code not at full current");
  a_phase_field_write : assert property (
    wr_ok && i_addr == DACG_ADDR_PHASE |=> ##1 o_sampling_phase == $past(i_wdata[7:DACG_PHASE_LSB], 2))
    else $error("sampling phase not applied");
  a_test_a_store : assert property (
    wr_ok && i_addr == DACG_ADDR_TEST_A |=> test_a_r == $past(i_wdata))
    else $error("first test register not stored");
  a_test_b_store : assert property (
    wr_ok && i_addr == DACG_ADDR_TEST_B |=> test_b_r == $past(i_wdata))
    else $error("second test register not stored");
  a_test_c_store : assert property (
    wr_ok && i_addr == DACG_ADDR_TEST_C |=> test_c_r == $past(i_wdata))
    else $error("third test register not stored");
  a_test_d_store : assert property (
    wr_ok && i_addr == DACG_ADDR_TEST_D |=> test_d_r == $past(i_wdata))
    else $error("fourth test register not stored");
  a_test_status_ok : assert property (
    o_test_regs_ok |-> $past(test_a_r) == DACG_REQ_TEST_A && $past(test_b_r) == DACG_REQ_TEST_B
    && $past(test_c_r) == DACG_REQ_TEST_C && $past(test_d_r) == DACG_REQ_TEST_D)
    else $error("test status set with wrong test values");
  a_gain_ctrl_store : assert property (
    wr_ok && i_addr == DACG_ADDR_GAIN_CTRL |=> gain_ctrl_r == $past(i_wdata))
    else $error("gain matching control not stored");
  a_ofs_hold_store : assert property (
    wr_ok && i_addr == DACG_ADDR_OFS_HOLD |=> ofs_hold_r == $past(i_wdata))
    else $error("offset hold control not stored");

  c_divisor_commit : cover property (div_bus.wr_high ##[1:4] div_bus.wr_low ##1 o_divisor_update);
  c_ext_clock_on : cover property ($rose(o_external_pixel_clock_select));
  c_gain_enabled : cover property ($rose(o_gain_update_allow));
  c_tests_loaded : cover property ($rose(o_test_regs_ok));
  c_offset_oneshot : cover property (o_offset_update_pulse);
endmodule : dacg_config_regs

// [dv/dacg_host_model.sv]
// host controller model driving the register port of the clock generator slice
`timescale 1ns/1ps
module dacg_host_model (
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_valid,
  output logic            o_wr_en,
  output logic            o_rd_en,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  import dacg_pkg::*;
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 8'hFF;
    o_wdata = 8'hFF;
  end
  // released lines show the inverse so a stale value never passes as current
  task automatic release_bus();
    #1;
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = ~o_addr;
    o_wdata = ~o_wdata;
  endtask : release_bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    #1;
    o_wr_en = 1'b1;
    o_addr  = a;
    o_wdata = d;
    @(posedge i_clk_sys);
    release_bus();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge i_clk_sys);
    #1;
    o_rd_en = 1'b1;
    o_addr  = a;
    @(posedge i_clk_sys);
    release_bus();
    d = 8'hXX;
    n = 0;
    while (i_rd_valid !== 1'b1 && n < 4) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    if (i_rd_valid === 1'b1) begin
      d = i_rd_data;
    end
  endtask : rd
  task automatic init_test_regs();
    wr(DACG_ADDR_TEST_A, DACG_REQ_TEST_A);
    wr(DACG_ADDR_TEST_B, DACG_REQ_TEST_B);
    wr(DACG_ADDR_TEST_C, DACG_REQ_TEST_C);
    wr(DACG_ADDR_TEST_D, DACG_REQ_TEST_D);
  endtask : init_test_regs
endmodule : dacg_host_model

// [dv/tb_top.sv]
// self-checking bench for the clock generator register slice
`timescale 1ns/1ps
module tb_top;
  import dacg_pkg::*;
  logic        i_clk_sys;
  logic        i_rstn;
  logic [11:0] lines;
  logic        wr_en, rd_en, rd_valid, ready, div_upd, div_use, ext;
  logic        ofs_cont, ofs_pulse, gain_en, gain_allow, test_ok;
  logic [7:0]  addr, wdata, rd_data;
  logic [11:0] div;
  logic [1:0]  band;
  logic [3:0]  post;
  logic [2:0]  pump;
  logic [10:0] pump_ua;
  logic [4:0]  phase;
  logic [15:0] cdeg;
  int          fail_count, n_tests, cycles;
  logic [10:0] ua_tab [8] = '{11'h032, 11'h064, 11'h096, 11'h0FA, 11'h15E, 11'h1F4, 11'h2EE, 11'h5DC};

  dacg_config_regs dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_wr_en(wr_en), .i_rd_en(rd_en),
    .i_addr(addr), .i_wdata(wdata), .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_regs_ready(ready),
    .i_lines_per_frame(lines), .o_line_clock_divisor(div), .o_divisor_update(div_upd),
    .o_divisor_in_use(div_use), .o_oscillator_band_select(band), .o_post_divider_ratio(post),
    .o_pump_current_code(pump), .o_pump_current_ua(pump_ua), .o_external_pixel_clock_select(ext),
    .o_sampling_phase(phase), .o_phase_shift_cdeg(cdeg), .o_offset_continuous(ofs_cont),
    .o_offset_update_pulse(ofs_pulse), .o_gain_match_enable(gain_en), .o_gain_update_allow(gain_allow),
    .o_test_regs_ok(test_ok));
  dacg_host_model host (.i_clk_sys(i_clk_sys), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
    .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));

  always #10 i_clk_sys = ~i_clk_sys;

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask : rchk
  // derived outputs lag their source register by one more edge
  task automatic settle();
    @(posedge i_clk_sys);
    #1;
  endtask : settle

  task automatic t_reset();
    chk(div, DACG_RST_DIVISOR);
    chk({band, pump, ext, div_use}, {2'h1, 3'h1, 1'b0, 1'b1});
    chk(pump_ua, 11'h064);
    chk({phase, cdeg}, {5'h10, 16'h4650});
    rchk(DACG_ADDR_DIV_HIGH, 8'h69);
    rchk(DACG_ADDR_DIV_LOW, DACG_RST_DIV_LOW);
    rchk(DACG_ADDR_CLKGEN, 8'h48);
    rchk(DACG_ADDR_TEST_A, 8'hBF);
    rchk(DACG_ADDR_TEST_B, 8'h02);
    rchk(DACG_ADDR_OFS_HOLD, 8'h00);
    rchk(DACG_ADDR_TEST_C, 8'hF0);
    rchk(DACG_ADDR_TEST_D, 8'hF0);
    rchk(DACG_ADDR_GAIN_CTRL, 8'h00);
    chk(test_ok, 1'b0);
  endtask : t_reset
  task automatic t_divisor();
    host.wr(DACG_ADDR_DIV_HIGH, 8'h10);
    chk(div, DACG_RST_DIVISOR);
    host.wr(DACG_ADDR_DIV_LOW, 8'h50);
    chk({div_upd, div}, {1'b1, 12'h105});
    host.wr(DACG_ADDR_DIV_HIGH, 8'h00);
    host.wr(DACG_ADDR_DIV_LOW, 8'h20);
    chk(div, 12'h002);
    host.wr(DACG_ADDR_DIV_LOW, 8'h10);
    chk({div_upd, div}, {1'b0, 12'h002});
    host.wr(DACG_ADDR_DIV_HIGH, 8'hFF);
    host.wr(DACG_ADDR_DIV_LOW, 8'hF0);
    chk(div, 12'hFFF);
    rchk(DACG_ADDR_DIV_LOW, 8'hF0);
  endtask : t_divisor
  task automatic t_clkgen();
    for (int i = 0; i < 8; i++) begin
      host.wr(DACG_ADDR_CLKGEN, {i[1:0], i[2:0], i[0], 2'b00});
      settle();
      chk({band, post}, {i[1:0], 4'h8 >> i[1:0]});
      chk({pump, pump_ua}, {i[2:0], ua_tab[i]});
      chk({ext, div_use, div}, {i[0], !i[0], 12'hFFF});
    end
  endtask : t_clkgen
  task automatic t_readonly();
    lines = 12'hABC;
    rchk(DACG_ADDR_LINES_HIGH, 8'hAB);
    host.wr(DACG_ADDR_LINES_LOW, 8'h55);
    rchk(DACG_ADDR_LINES_LOW, 8'hC0);
    host.wr(DACG_ADDR_REVISION, 8'hA5);
    rchk(DACG_ADDR_REVISION, DACG_REVISION_DFLT);
    for (int a = 8'h2A; a <= 8'h2B; a++) begin
      rchk(a[7:0], DACG_ZERO_BYTE);
      host.wr(a[7:0], 8'hFF);
      rchk(a[7:0], DACG_ZERO_BYTE);
    end
    rchk(8'h50, DACG_ZERO_BYTE);
  endtask : t_readonly
  task automatic t_offset_gain();
    host.wr(DACG_ADDR_OFS_HOLD, 8'h10);
    settle();
    chk(ofs_cont, 1'b1);
    host.wr(DACG_ADDR_OFS_HOLD, 8'h00);
    settle();
    chk({ofs_cont, ofs_pulse}, 2'b01);
    settle();
    chk(ofs_pulse, 1'b0);
    host.wr(DACG_ADDR_GAIN_CTRL, 8'h06);
    settle();
    chk({gain_en, gain_allow}, 2'b10);
    host.wr(DACG_ADDR_GAIN_CTRL, 8'h0E);
    settle();
    chk({gain_en, gain_allow}, 2'b11);
    host.wr(DACG_ADDR_GAIN_CTRL, 8'h08);
    settle();
    chk({gain_en, gain_allow}, 2'b00);
  endtask : t_offset_gain
  task automatic t_test_phase();
    host.init_test_regs();
    settle();
    chk(test_ok, 1'b1);
    rchk(DACG_ADDR_TEST_D, 8'hE0);
    host.wr(DACG_ADDR_PHASE, 8'hF8);
    settle();
    chk({phase, cdeg}, {5'h1F, 16'h883B});
  endtask : t_test_phase

  // ceiling is some forty times the expected run length
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    i_clk_sys = 1'b0;
    i_rstn = 1'b0;
    lines = 12'h000;
    repeat (5) @(posedge i_clk_sys);
    host.wr(DACG_ADDR_DIV_HIGH, 8'h00);
    chk(ready, 1'b0);
    @(posedge i_clk_sys);
    #1;
    i_rstn = 1'b1;
    for (int n = 0; n < 4 && ready !== 1'b1; n++) begin
      settle();
    end
    chk(ready, 1'b1);
    t_reset();
    t_divisor();
    t_clkgen();
    t_readonly();
    t_offset_gain();
    t_test_phase();
    end_sim();
  end
endmodule : tb_top
